// >>> logic/target_seq.sv
// target-mode multiphase sequencer: select/receive cdb and conclude
// assumes bus handshake is done outside; bytes arrive as one-cycle strobes
//
// Contract
// - atn variant command phase code 3, done 4
// - bus reset ends any phase with flag
// - chip reset or master reset aborts
// - reselection while waiting: code 0, reselected
// - pause while waiting: code 0, halted
// - message parity: first two halt too
// - non-identify message: unexpected message flag
// - atn variant without atn: code 6, halt
// - atn held after identify: attention flag
// - atn variant cdb parity: first halts too
// - full cdb received: code 4, done flag
// - accepted disconnected or target; waits selection only if disconnected
// - no-atn variant, atn seen: code 0
// - attention disable suppresses no-atn variant atn termination after selection
// - no-atn variant code 1; parity like cdb
// - deviation ends command; code keeps last
// - conclude: status, command complete, release bsy
// - done flag after disconnect only if enabled
// - atn variant, atn after selection: code 1, continue
// - identify goes to logical unit register
`timescale 1ns/1ps
`include "seq_defines.svh"
module target_seq (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // processor command port
  input  wire logic                  cmd_valid_in,
  input  wire seq_pkg::seq_cmd_e     cmd_in,
  input  wire logic                  chip_reset_cmd_in,
  input  wire logic                  pause_cmd_in,
  input  wire logic                  master_reset_input_n_in,
  input  wire logic                  attention_disable_bit_in,
  input  wire logic                  function_done_irq_enable_in,
  // status read clears
  input  wire logic [`FI_WIDTH-1:0]  functional_irq_status_reg_clear_in,
  input  wire logic [`EI_WIDTH-1:0]  error_irq_status_reg_clear_in,
  // scsi bus events
  input  wire logic                  selected_in,
  input  wire logic                  reselected_in,
  input  wire logic                  atn_in,
  input  wire logic                  bus_reset_in,
  // received byte
  input  wire logic                  rx_valid_in,
  input  wire logic [7:0]            rx_data_in,
  input  wire logic                  rx_parity_err_in,
  // transmitted byte
  output logic                       tx_valid_out,
  output logic      [7:0]            tx_data_out,
  input  wire logic                  tx_ack_in,
  // transmit fifo head
  input  wire logic [7:0]            status_byte_in,
  output logic                       status_pop_out,
  // receive fifo
  output logic                       rx_fifo_push_out,
  output logic      [7:0]            rx_fifo_data_out,
  // state
  output logic      [2:0]            phase_out,
  output logic                       bsy_out,
  output logic                       busy_out,
  output logic      [3:0]            state_code_out,
  output logic      [7:0]            logical_unit_register_out,
  output logic [`FI_WIDTH-1:0]       functional_irq_status_reg_out,
  output logic [`EI_WIDTH-1:0]       error_irq_status_reg_out
);
  import seq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_state_e             state_q, state_d;
  logic                   atn_var_q;
  logic                   target_q;
  logic [3:0]             code_d;
  logic [1:0]             msg_cnt_q;
  logic [4:0]             byte_cnt_q;
  logic [4:0]             cdb_len;
  logic [`FI_WIDTH-1:0]   fset_d, fset_q;
  logic [`EI_WIDTH-1:0]   eset_d, eset_q;
  logic                   push_d, lun_load_d, len_load_d;
  logic                   abort;
  logic                   first_byte;

  assign abort      = chip_reset_cmd_in || !master_reset_input_n_in;
  assign first_byte = (byte_cnt_q == 5'h00);

  // ----------------------------------------------------------------
  // sequencing decisions
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    code_d     = state_code_out;
    fset_d     = '0;
    eset_d     = '0;
    push_d     = 1'b0;
    lun_load_d = 1'b0;
    len_load_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid_in) begin
          case (cmd_in)
            CMD_WAIT_ATN, CMD_WAIT_NOATN: begin
              state_d = target_q ? ST_SEL_CHK : ST_WAIT_SEL;
            end
            CMD_CONCLUDE: begin
              if (target_q) begin
                state_d = ST_STATUS_IN;
              end
            end
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_WAIT_SEL: begin
        if (pause_cmd_in) begin
          code_d             = `CODE_SEL_FAIL;
          eset_d[`EI_HALT]   = 1'b1;
          state_d            = ST_IDLE;
        end else if (reselected_in) begin
          code_d             = `CODE_SEL_FAIL;
          fset_d[`FI_RESEL]  = 1'b1;
          state_d            = ST_IDLE;
        end else if (selected_in) begin
          state_d            = ST_SEL_CHK;
        end
      end
      ST_SEL_CHK: begin
        if (atn_var_q) begin
          if (!atn_in) begin
            code_d           = `CODE_NO_ATN;
            eset_d[`EI_HALT] = 1'b1;
            state_d          = ST_IDLE;
          end else begin
            code_d           = `CODE_SEL_OK;
            state_d          = ST_MSG_OUT;
          end
        end else if (atn_in && !attention_disable_bit_in) begin
          code_d             = `CODE_SEL_FAIL;
          fset_d[`FI_ATTN]   = 1'b1;
          state_d            = ST_IDLE;
        end else begin
          code_d             = `CODE_SEL_OK;
          state_d            = ST_CMD_OUT;
        end
      end
      ST_MSG_OUT: begin
        if (rx_valid_in) begin
          if (rx_parity_err_in) begin
            eset_d[`EI_PARITY] = 1'b1;
            eset_d[`EI_HALT]   = (msg_cnt_q < 2'h2);
            state_d            = ST_IDLE;
          end else if (rx_data_in[`MSG_IDENT_BIT]) begin
            lun_load_d         = 1'b1;
            code_d             = `CODE_ID_RCVD;
            state_d            = ST_ATN_CHK;
          end else begin
            push_d             = 1'b1;
            eset_d[`EI_UNEXP]  = 1'b1;
            state_d            = ST_IDLE;
          end
        end
      end
      ST_ATN_CHK: begin
        if (atn_in) begin
          fset_d[`FI_ATTN]   = 1'b1;
          state_d            = ST_IDLE;
        end else begin
          code_d             = `CODE_CDB_START;
          state_d            = ST_CMD_OUT;
        end
      end
      ST_CMD_OUT: begin
        if (rx_valid_in) begin
          if (rx_parity_err_in) begin
            eset_d[`EI_PARITY] = 1'b1;
            eset_d[`EI_HALT]   = first_byte;
            state_d            = ST_IDLE;
          end else begin
            push_d             = 1'b1;
            len_load_d         = first_byte;
            if (!first_byte && (byte_cnt_q + 5'h01 == cdb_len)) begin
              code_d           = `CODE_CDB_DONE;
              fset_d[`FI_DONE] = 1'b1;
              state_d          = ST_IDLE;
            end
          end
        end
      end
      ST_STATUS_IN: begin
        if (tx_ack_in) begin
          code_d             = `CODE_STAT_SENT;
          if (atn_in) begin
            fset_d[`FI_ATTN] = 1'b1;
            state_d          = ST_IDLE;
          end else begin
            state_d          = ST_MSG_IN;
          end
        end
      end
      ST_MSG_IN: begin
        if (tx_ack_in) begin
          code_d             = `CODE_CC_SENT;
          if (atn_in) begin
            fset_d[`FI_ATTN] = 1'b1;
            state_d          = ST_IDLE;
          end else begin
            state_d          = ST_DISC;
          end
        end
      end
      ST_DISC: begin
        fset_d[`FI_DONE] = function_done_irq_enable_in;
        state_d          = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (bus_reset_in && (state_q != ST_IDLE)) begin
      fset_d[`FI_BUS_RST] = 1'b1;
      state_d             = ST_IDLE;
    end
    if (abort) begin
      state_d = ST_IDLE;
      code_d  = state_code_out;
      fset_d  = '0;
      eset_d  = '0;
      push_d  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      busy_out <= 1'b0;
    end else begin
      state_q  <= state_d;
      busy_out <= (state_d != ST_IDLE);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      atn_var_q <= 1'b0;
    end else if ((state_q == ST_IDLE) && cmd_valid_in) begin
      atn_var_q <= (cmd_in == CMD_WAIT_ATN);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_code_out <= `CODE_SEL_FAIL;
    end else begin
      state_code_out <= code_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || abort) begin
      target_q <= 1'b0;
    end else if ((state_q == ST_DISC) || (bus_reset_in && (state_q != ST_IDLE))) begin
      target_q <= 1'b0;
    end else if ((state_q == ST_WAIT_SEL) && (state_d == ST_SEL_CHK)) begin
      target_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      msg_cnt_q  <= 2'h0;
      byte_cnt_q <= 5'h00;
    end else if (state_q == ST_SEL_CHK || state_q == ST_IDLE) begin
      msg_cnt_q  <= 2'h0;
      byte_cnt_q <= 5'h00;
    end else if (rx_valid_in) begin
      if (state_q == ST_MSG_OUT && msg_cnt_q != 2'h3) begin
        msg_cnt_q <= msg_cnt_q + 2'h1;
      end
      if (state_q == ST_CMD_OUT) begin
        byte_cnt_q <= byte_cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus side datapath
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_valid_out   <= 1'b0;
      tx_data_out    <= 8'h00;
      status_pop_out <= 1'b0;
    end else begin
      status_pop_out <= 1'b0;
      if (tx_ack_in || state_d == ST_IDLE) begin
        tx_valid_out <= 1'b0;
      end
      if (state_d == ST_STATUS_IN && state_q != ST_STATUS_IN) begin
        tx_valid_out   <= 1'b1;
        tx_data_out    <= status_byte_in;
        status_pop_out <= 1'b1;
      end else if (state_d == ST_MSG_IN && state_q != ST_MSG_IN) begin
        tx_valid_out <= 1'b1;
        tx_data_out  <= `MSG_CMD_DONE;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_fifo_push_out          <= 1'b0;
      rx_fifo_data_out          <= 8'h00;
      logical_unit_register_out <= 8'h00;
    end else begin
      rx_fifo_push_out <= push_d;
      if (push_d) begin
        rx_fifo_data_out <= rx_data_in;
      end
      if (lun_load_d && !abort) begin
        logical_unit_register_out <= rx_data_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase_out <= `PH_BUS_FREE;
      bsy_out   <= 1'b0;
    end else begin
      bsy_out <= target_q;
      case (state_d)
        ST_MSG_OUT, ST_ATN_CHK: phase_out <= `PH_MSG_OUT;
        ST_CMD_OUT:             phase_out <= `PH_COMMAND;
        ST_STATUS_IN:           phase_out <= `PH_STATUS;
        ST_MSG_IN:              phase_out <= `PH_MSG_IN;
        default:                phase_out <= `PH_BUS_FREE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flags and cdb length
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fset_q <= `FI_RESET;
      eset_q <= `EI_RESET;
    end else begin
      fset_q <= fset_d;
      eset_q <= eset_d;
    end
  end

  sticky_flags #(.W(`FI_WIDTH), .RST(`FI_RESET)) u_functional_irq_status_reg (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .set_in    (fset_q),
    .clear_in  (functional_irq_status_reg_clear_in),
    .flags_out (functional_irq_status_reg_out)
  );

  sticky_flags #(.W(`EI_WIDTH), .RST(`EI_RESET)) u_error_irq_status_reg (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .set_in    (eset_q),
    .clear_in  (error_irq_status_reg_clear_in),
    .flags_out (error_irq_status_reg_out)
  );

  cdb_len_decoder u_len (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .load_in   (len_load_d),
    .opcode_in (rx_data_in),
    .len_out   (cdb_len)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_flag_seen(int b);
    fset_q[b] ##1 functional_irq_status_reg_out[b];
  endsequence

  a_sel_ok_code: assert property (
    (state_q == ST_SEL_CHK && atn_var_q && atn_in && !abort && !bus_reset_in)
      |=> (state_code_out == 4'h1 && state_q == ST_MSG_OUT && fset_q == '0 && eset_q == '0))
    else $error("atn after selection not continued");
  a_cdb_start_code: assert property (
    (state_q == ST_ATN_CHK && !atn_in && !abort && !bus_reset_in) |=> (state_code_out == 4'h3 && state_q == ST_CMD_OUT))
    else $error("cdb start code not 3");
  a_bus_reset_end: assert property (
    (busy_out && bus_reset_in && !abort) |=> !busy_out ##0 s_flag_seen(`FI_BUS_RST))
    else $error("bus reset did not end command");
  a_abort_idle: assert property (
    abort |=> (state_q == ST_IDLE && !busy_out && $stable(state_code_out)))
    else $error("abort did not stop command");
  a_resel_code: assert property (
    (state_q == ST_WAIT_SEL && reselected_in && !pause_cmd_in && !abort && !bus_reset_in)
      |=> state_code_out == 4'h0 ##0 s_flag_seen(`FI_RESEL))
    else $error("reselection not reported");
  a_pause_halt: assert property (
    (state_q == ST_WAIT_SEL && pause_cmd_in && !abort && !bus_reset_in)
      |=> (state_code_out == 4'h0 && eset_q[`EI_HALT]) ##1 error_irq_status_reg_out[`EI_HALT])
    else $error("pause not reported");
  a_no_atn_halt: assert property (
    (state_q == ST_SEL_CHK && atn_var_q && !atn_in && !abort && !bus_reset_in)
      |=> (state_code_out == 4'h6 && eset_q[`EI_HALT] && !busy_out))
    else $error("missing atn not halted");
  a_cdb_parity_first: assert property (
    (state_q == ST_CMD_OUT && rx_valid_in && rx_parity_err_in && !abort && !bus_reset_in)
      |=> (eset_q[`EI_PARITY] && (eset_q[`EI_HALT] == $past(first_byte)) && !rx_fifo_push_out))
    else $error("cdb parity flags wrong");
  a_atn_noatn_var: assert property (
    (state_q == ST_SEL_CHK && !atn_var_q && atn_in && !attention_disable_bit_in && !abort && !bus_reset_in)
      |=> (state_code_out == 4'h0 && fset_q[`FI_ATTN]))
    else $error("atn in no-atn variant not reported");
  a_conclude_done: assert property (
    (state_q == ST_DISC && !abort && !bus_reset_in)
      |=> (fset_q[`FI_DONE] == $past(function_done_irq_enable_in)) ##1 (!bsy_out)[*2])
    else $error("conclude done flag wrong");
  a_identify_lun: assert property (
    (state_q == ST_MSG_OUT && rx_valid_in && !rx_parity_err_in && rx_data_in[7] && !abort && !bus_reset_in)
      |=> (logical_unit_register_out == $past(rx_data_in) && state_code_out == 4'h2 && !rx_fifo_push_out))
    else $error("identify not stored");
endmodule // target_seq

// >>> logic/seq_defines.svh
// constants for the target select / cdb / conclude sequencer
// assumes inclusion by bare name from the design files
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// command state codes
`define CODE_SEL_FAIL   4'h0
`define CODE_SEL_OK     4'h1
`define CODE_ID_RCVD    4'h2
`define CODE_CDB_START  4'h3
`define CODE_CDB_DONE   4'h4
`define CODE_NO_ATN     4'h6
`define CODE_STAT_SENT  4'hC
`define CODE_CC_SENT    4'hD

// functional status bit positions
`define FI_RESEL        0
`define FI_ATTN         1
`define FI_DONE         2
`define FI_BUS_RST      3
`define FI_WIDTH        4

// error status bit positions
`define EI_PARITY       0
`define EI_HALT         1
`define EI_UNEXP        2
`define EI_WIDTH        3

// reset values
`define FI_RESET        4'h0
`define EI_RESET        3'h0
`define LEN_RESET       5'h00

// bus phase codes {msg, c_d, i_o}
`define PH_BUS_FREE     3'h0
`define PH_COMMAND      3'h2
`define PH_STATUS       3'h3
`define PH_MSG_OUT      3'h6
`define PH_MSG_IN       3'h7

// message bytes
`define MSG_CMD_DONE    8'h00
`define MSG_IDENT_BIT   7

`endif

// >>> logic/seq_pkg.sv
// types for the target select / cdb / conclude sequencer
// assumes seq_defines.svh is on the include path
package seq_pkg;
  typedef enum logic [1:0] {CMD_NONE, CMD_WAIT_ATN, CMD_WAIT_NOATN, CMD_CONCLUDE} seq_cmd_e;
  typedef enum {ST_IDLE, ST_WAIT_SEL, ST_SEL_CHK, ST_MSG_OUT, ST_ATN_CHK, ST_CMD_OUT,
                ST_STATUS_IN, ST_MSG_IN, ST_DISC} seq_state_e;

  // cdb length from the group code of the opcode
  function automatic logic [4:0] cdb_length(input logic [7:0] opcode);
    case (opcode[7:5])
      3'h0:    cdb_length = 5'h06;
      3'h1:    cdb_length = 5'h0A;
      3'h2:    cdb_length = 5'h0A;
      3'h5:    cdb_length = 5'h0C;
      default: cdb_length = 5'h06;
    endcase
  endfunction
endpackage

// >>> logic/sticky_flags.sv
// sticky status flags, set wins over clear
// assumes one-cycle set and clear pulses on clk_in
`timescale 1ns/1ps
module sticky_flags #(
  parameter int         W     = 4,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // set and clear
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clear_in,
  // flags
  output logic      [W-1:0] flags_out
);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_out <= RST;
    end else begin
      flags_out <= (flags_out & ~clear_in) | set_in;
    end
  end
endmodule // sticky_flags

// >>> logic/cdb_len_decoder.sv
// registered cdb length decoder
// assumes load_in pulses with the first command byte
`timescale 1ns/1ps
`include "seq_defines.svh"
module cdb_len_decoder (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // opcode
  input  wire logic       load_in,
  input  wire logic [7:0] opcode_in,
  // length
  output logic      [4:0] len_out
);
  import seq_pkg::*;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      len_out <= `LEN_RESET;
    end else if (load_in) begin
      len_out <= cdb_length(opcode_in);
    end
  end
endmodule // cdb_len_decoder

// >>> tb/scsi_initiator_model.sv
// initiator model: selection, atn, byte stream out, acknowledge of offered bytes
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/1ps
module scsi_initiator_model (
  // clock
  input  wire logic       clk_in,
  // target offer
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic [2:0] phase_in,
  // bus events and bytes
  output logic            selected_out,
  output logic            atn_out,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_parity_err_out,
  output logic            tx_ack_out
);
  int          ack_delay = 0;
  int          wait_n    = 0;
  logic [10:0] tx_log[$];

  initial begin
    {selected_out, atn_out, rx_valid_out, rx_parity_err_out, tx_ack_out} = 5'h00;
    rx_data_out = 8'h00;
  end

  task automatic sel(input logic s, input logic a);
    selected_out = s;
    atn_out      = a;
  endtask

  // bytes streamed back to back, no processor handshake
  task automatic send(input logic [7:0] b, input logic pe);
    rx_valid_out      = 1'b1;
    rx_data_out       = b;
    rx_parity_err_out = pe;
    @(posedge clk_in);
    #1;
  endtask

  // released data lines show the inverse, not the last byte
  task automatic idle(input logic a);
    rx_valid_out      = 1'b0;
    rx_data_out       = ~rx_data_out;
    rx_parity_err_out = 1'b0;
    atn_out           = a;
  endtask

  // one ack pulse per offered byte, after ack_delay cycles
  always @(posedge clk_in) begin
    #1;
    if (tx_ack_out) begin
      tx_ack_out = 1'b0;
    end else if (tx_valid_in && wait_n >= ack_delay) begin
      tx_log.push_back({phase_in, tx_data_in});
      tx_ack_out = 1'b1;
      wait_n     = 0;
    end else if (tx_valid_in) begin
      wait_n++;
    end
  end
endmodule // scsi_initiator_model

// >>> tb/target_seq_bench.sv
// bench for target_seq: select and cdb, aborts, conclude
// assumes 200 MHz clock and sync active-low reset
`timescale 1ns/1ps
`include "seq_defines.svh"
module target_seq_bench;
  import seq_pkg::*;
  logic clk_in, rst_n_in, cmd_valid, chip_rst, pause, mr_n, atn_dis, fc_en, resel, bus_rst;
  logic selected, atn, rx_valid, rx_pe, tx_valid, tx_ack, status_pop, push, bsy, busy;
  logic [7:0] rx_data, tx_data, status_byte, push_data, logical_unit_register;
  logic [3:0] fi_clr, fi, code;
  logic [2:0] ei_clr, ei, phase;
  seq_cmd_e   cmd;
  int         bad_count = 0, tests_run = 0, pops = 0, tno = 0;
  logic [7:0] pushes[$];
  logic [3:0] af[5] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h8};
  logic [2:0] ae[5] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0};

  target_seq u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .chip_reset_cmd_in(chip_rst), .pause_cmd_in(pause), .master_reset_input_n_in(mr_n),
    .attention_disable_bit_in(atn_dis), .function_done_irq_enable_in(fc_en), .functional_irq_status_reg_clear_in(fi_clr),
    .error_irq_status_reg_clear_in(ei_clr), .selected_in(selected), .reselected_in(resel), .atn_in(atn),
    .bus_reset_in(bus_rst), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_parity_err_in(rx_pe),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ack_in(tx_ack), .status_byte_in(status_byte),
    .status_pop_out(status_pop), .rx_fifo_push_out(push), .rx_fifo_data_out(push_data),
    .phase_out(phase), .bsy_out(bsy), .busy_out(busy), .state_code_out(code),
    .logical_unit_register_out(logical_unit_register), .functional_irq_status_reg_out(fi), .error_irq_status_reg_out(ei));
  scsi_initiator_model u_ini (.clk_in(clk_in), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .phase_in(phase), .selected_out(selected), .atn_out(atn), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_parity_err_out(rx_pe), .tx_ack_out(tx_ack));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic clr;
    fi_clr = 4'hF;
    ei_clr = 3'h7;
    cyc(1);
    fi_clr = 4'h0;
    ei_clr = 3'h0;
  endtask
  task automatic issue(input seq_cmd_e c);
    cmd_valid = 1'b1;
    cmd       = c;
    cyc(1);
    cmd_valid = 1'b0;
    cyc(1);
  endtask
  task automatic wait_end;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) cyc(1);
    chk(busy, 11'h000, "busy stuck");
  endtask
  task automatic wait_ph(input logic [2:0] p);
    for (int i = 0; i < 20 && busy === 1'b1 && phase !== p; i++) cyc(1);
  endtask
  function automatic logic [7:0] cdb_b(input int i, input logic [7:0] op);
    return (i == 0) ? op : 8'(16 + i);
  endfunction
  task automatic run(input seq_cmd_e c, input logic a1, a2, input logic [7:0] m, op,
                     input int n, pe, np, input logic [3:0] xc, xf, input logic [2:0] xe);
    clr();
    pushes.delete();
    u_ini.sel(bsy !== 1'b1, a1);
    issue(c);
    wait_ph((c == CMD_WAIT_ATN) ? `PH_MSG_OUT : `PH_COMMAND);
    u_ini.sel(1'b0, a1);
    if (c == CMD_WAIT_ATN && busy === 1'b1) begin
      u_ini.send(m, pe == 0);
      u_ini.idle(a2);
      wait_ph(`PH_COMMAND);
    end
    for (int i = 0; i < n && busy === 1'b1; i++) u_ini.send(cdb_b(i, op), pe == i + 1);
    u_ini.idle(1'b0);
    wait_end();
    cyc(2);
    chk(code, xc, "state code");
    chk(fi, xf, "functional flags");
    chk(ei, xe, "error flags");
    chk(11'(pushes.size()), 11'(np), "push count");
    foreach (pushes[i]) chk(pushes[i], m[7] ? cdb_b(i, op) : m, "fifo byte");
    tno++;
    $display("test %0d done", tno);
  endtask
  task automatic conclude(input logic en, input int d, input logic [7:0] st);
    clr();
    fc_en       = en;  // done flag wanted for later reconnects
    status_byte = st;  // status byte at fifo head before the command
    u_ini.ack_delay = d;
    u_ini.tx_log.delete();
    pops = 0;
    issue(CMD_CONCLUDE);
    wait_end();
    cyc(3);
    chk(11'(u_ini.tx_log.size()), 11'h002, "tx count");
    chk(u_ini.tx_log[0], {`PH_STATUS, st}, "status byte");
    chk(u_ini.tx_log[1], {`PH_MSG_IN, `MSG_CMD_DONE}, "complete msg");
    chk(11'(pops), 11'h001, "status pops");
    chk({bsy, code}, {1'b0, `CODE_CC_SENT}, "bsy and code");
    chk(fi, {1'b0, en, 2'b00}, "done flag");
    tno++;
    $display("test %0d done", tno);
  endtask

  always @(posedge clk_in) begin
    if (push === 1'b1) pushes.push_back(push_data);
    if (status_pop === 1'b1) pops++;
  end

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // more than a hundred times the expected run
  initial begin
    #100000;
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    results();
  end
  initial begin
    {rst_n_in, cmd_valid, chip_rst, pause, resel, bus_rst, atn_dis, fc_en} = 8'h00;
    cmd = CMD_NONE;
    {mr_n, fi_clr, ei_clr, status_byte} = {1'b1, 4'h0, 3'h0, 8'h00};
    repeat (3) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    chk({bsy, busy, code, fi, ei}, 11'h000, "reset values");
    for (int k = 0; k < 5; k++) begin
      clr();
      issue(CMD_WAIT_ATN);
      case (k)
        0: pause = 1'b1;
        1: resel = 1'b1;
        2: mr_n = 1'b0;
        3: chip_rst = 1'b1;
        default: bus_rst = 1'b1;
      endcase
      cyc(1);
      {pause, resel, chip_rst, bus_rst, mr_n} = 5'h01;
      if (k == 2 || k == 3) chk(busy, 11'h000, "abort busy");
      cyc(2);
      chk({busy, code, fi, ei}, {1'b0, 4'h0, af[k], ae[k]}, "abort result");
    end
    run(CMD_WAIT_ATN, 1, 0, 8'h85, 8'h08, 6, -1, 6, `CODE_CDB_DONE, 4'h4, 3'h0);
    chk(logical_unit_register, 8'h85, "lun");
    conclude(1'b1, 3, 8'h3A);
    atn_dis = 1'b1;
    run(CMD_WAIT_NOATN, 1, 0, 8'h80, 8'h28, 10, 4, 3, `CODE_SEL_OK, 4'h0, 3'h1);
    atn_dis = 1'b0;
    conclude(1'b0, 0, 8'h02);
    run(CMD_WAIT_NOATN, 1, 0, 8'h80, 8'h28, 10, -1, 0, `CODE_SEL_FAIL, 4'h2, 3'h0);
    chip_rst = 1'b1;
    cyc(1);
    chip_rst = 1'b0;
    cyc(1);
    chk({busy, bsy}, 11'h000, "chip reset");
    run(CMD_WAIT_ATN, 0, 0, 8'h85, 8'h08, 6, -1, 0, `CODE_NO_ATN, 4'h0, 3'h2);
    run(CMD_WAIT_ATN, 1, 0, 8'h85, 8'h08, 6, 0, 0, `CODE_SEL_OK, 4'h0, 3'h3);
    run(CMD_WAIT_ATN, 1, 0, 8'h05, 8'h08, 6, -1, 1, `CODE_SEL_OK, 4'h0, 3'h4);
    run(CMD_WAIT_ATN, 1, 1, 8'h85, 8'h08, 6, -1, 0, `CODE_ID_RCVD, 4'h2, 3'h0);
    run(CMD_WAIT_ATN, 1, 0, 8'h85, 8'hA0, 12, 1, 0, `CODE_CDB_START, 4'h0, 3'h3);
    run(CMD_WAIT_ATN, 1, 0, 8'h85, 8'hA0, 12, -1, 12, `CODE_CDB_DONE, 4'h4, 3'h0);
    run(CMD_WAIT_NOATN, 0, 0, 8'h80, 8'h20, 10, 1, 0, `CODE_SEL_OK, 4'h0, 3'h3);
    results();
  end
endmodule // target_seq_bench
